// ===== sim/rilm_slave_model.sv
/*
  Behavioural chain of remote slaves answering the link master.
  Assumes polls arrive as one-cycle strobes sampled on pclk.
*/
`default_nettype none
module rilm_slave_model
  import rilm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        poll_strobe,
  input  wire logic [4:0]  poll_addr,
  input  wire logic [15:0] poll_data,
  input  wire logic [27:0] present,
  input  wire logic        fail_on,
  input  wire logic        slow,
  input  wire logic [15:0] in_word,
  output logic             link_ack,
  output logic             link_err,
  output logic [15:0]      link_data,
  output logic [1:0]       link_width,
  output logic [15:0]      out_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] a;
  // Series chain seen as one bus: order and terminator are invisible here
  initial begin
    link_ack = 1'h0;
    link_err = 1'h0;
    link_data = 16'h5A5A;
    link_width = 2'h3;
    out_seen = 16'h0000;
    forever begin
      @(posedge pclk);
      if (presetn && poll_strobe === 1'h1 && present[poll_addr]) begin
        a = poll_addr;
        if (a == 5'h00) out_seen = poll_data;
        repeat (slow ? 20 : 2) @(posedge pclk);
        link_data  <= (a == 5'h08) ? in_word : {12'h000, a[0] ? 4'h9 : 4'h6};
        link_width <= (a[3:2] == 2'h3) ? PT4 : 2'h2;
        repeat (3) @(posedge pclk);
        // Failing unit shows a line fault instead of an answer
        if (fail_on && a == 5'h08) link_err <= 1'h1;
        else link_ack <= 1'h1;
        repeat (4) @(posedge pclk);
        link_ack <= 1'h0;
        link_err <= 1'h0;
        // Released lines show the inverse, never stale data
        link_data <= ~link_data;
        link_width <= ~link_width;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/rilm_top_test.sv
/*
  Self-checking bench of the remote I/O link master and a slave chain.
  Assumes the zero-wait APB slave and short slots set by SLOT_CYCLES.
*/
`default_nettype none
module rilm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rilm_pkg::*;
  localparam int SLOT = 40;
  // Each slot adds its pick cycle, each skipped address one cycle
  localparam int SCAN = 7 * (SLOT + 1) + (N_ADDR - 5);
  // Reads cost a few cycles more
  localparam int LAT = 2 * SCAN + 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        link_ack, link_err, size_one_word, poll_strobe, link_ready, irq;
  logic        fail_on, slow, rd_e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [15:0] link_data, poll_data, in_word, out_seen;
  logic [1:0]  link_width;
  logic [4:0]  poll_addr;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  rilm_top #(.SLOT_CYCLES(SLOT)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_ack(link_ack), .link_err(link_err),
    .link_data(link_data), .link_width(link_width), .size_one_word(size_one_word),
    .poll_strobe(poll_strobe), .poll_addr(poll_addr), .poll_data(poll_data),
    .link_ready(link_ready), .irq(irq));
  rilm_slave_model slaves (.pclk(pclk), .presetn(presetn), .poll_strobe(poll_strobe),
    .poll_addr(poll_addr), .poll_data(poll_data), .present(28'h0003111),
    .fail_on(fail_on), .slow(slow), .in_word(in_word), .link_ack(link_ack),
    .link_err(link_err), .link_data(link_data), .link_width(link_width),
    .out_seen(out_seen));

  initial pclk = 1'h0;
  always #2 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd_v);
  endtask

  task automatic wait_for(input logic lvl, input int lim, output int n);
    n = 0;
    while (link_ready !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic t_disc();
    int n;
    chk("ready_at_reset", 32'h0, {31'h0, link_ready});
    rdc("stat_discovering", A_STAT, 32'h2);
    wait_for(1'h1, 8000, n);
    chk("disc_length", 32'h1, {31'h0, n >= 83 * SLOT});
    rdc("stat_ready", A_STAT, 32'h1);
    rdc("present_map", A_PRES, 32'h0003111);
  endtask

  task automatic t_regs();
    rdc("unmapped_data", 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rd_e});
    rdc("ctrl_reset", A_CTRL, 32'h0);
    apb(1'h1, A_STAT, 32'hFFFFFFFF);
    rdc("stat_read_only", A_STAT, 32'h1);
  endtask

  task automatic t_irq();
    rdc("istat_ready_event", A_ISTAT, 32'h2);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'h1, A_IMASK, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq_raised", 32'h1, {31'h0, irq});
    apb(1'h1, A_ISTAT, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    rdc("istat_cleared", A_ISTAT, 32'h0);
  endtask

  task automatic t_io();
    int t0;
    repeat (SCAN) @(posedge pclk);
    rdc("word2_16pt", A_WORD0 + 8'h08, 32'hA5C3);
    rdc("word3_nibbles", A_WORD0 + 8'h0C, 32'h0096);
    if (link_ready === 1'h1) apb(1'h1, A_WORD0, 32'h1234);
    repeat (2 * SCAN) @(posedge pclk);
    chk("out_polled", 32'h1234, {16'h0, out_seen});
    in_word <= 16'h3C3C;
    slow <= 1'h1;
    t0 = cyc;
    rd_v = 32'h0;
    while (rd_v !== 32'h3C3C && cyc - t0 < 1000) apb(1'h0, A_WORD0 + 8'h08, 32'h0);
    chk("latency_bound", 32'h1, {31'h0, cyc - t0 <= LAT});
    slow <= 1'h0;
  endtask

  task automatic t_err(input logic [31:0] ctl, input logic [15:0] exp_out);
    int n;
    apb(1'h1, A_CTRL, ctl);
    apb(1'h1, A_IMASK, 32'h1);
    fail_on <= 1'h1;
    wait_for(1'h0, 2000, n);
    chk("drop_time", 32'h1, {31'h0, n <= SCAN + SLOT});
    repeat (3) @(posedge pclk);
    chk("irq_link_err", 32'h1, {31'h0, irq});
    repeat (2 * SLOT) @(posedge pclk);
    chk("out_on_error", {16'h0, exp_out}, {16'h0, out_seen});
    if (ctl[0]) rdc("in_held", A_WORD0 + 8'h08, 32'h3C3C);
    else rdc("in_cleared", A_WORD0 + 8'h08, 32'h0);
    fail_on <= 1'h0;
    wait_for(1'h1, 8000, n);
    chk("ready_back", 32'h1, {31'h0, link_ready});
    apb(1'h1, A_ISTAT, 32'h7);
  endtask

  task automatic t_cfg();
    size_one_word <= 1'h1;
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4 * 28 * SLOT) @(posedge pclk);
    apb(1'h0, A_STAT, 32'h0);
    chk("cfg_flag", 32'h4, rd_v & 32'h5);
    chk("cfg_no_ready", 32'h0, {31'h0, link_ready});
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    size_one_word = 1'h0;
    fail_on = 1'h0;
    slow = 1'h0;
    in_word = 16'hA5C3;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_disc();
    t_regs();
    t_irq();
    t_io();
    t_err(32'h3, 16'h1234);
    t_err(32'h0, 16'h0000);
    t_cfg();
    finish_test();
  end
endmodule
`default_nettype wire

// ===== src/rilm_pkg.sv
/*
  Constants, register map and types of the remote I/O link master.
  Assumes one 250 MHz clock and an APB master with 32-bit data.
*/
`default_nettype none
package rilm_pkg;
  localparam logic [7:0]  A_CTRL  = 8'h00;
  localparam logic [7:0]  A_STAT  = 8'h04;
  localparam logic [7:0]  A_ISTAT = 8'h08;
  localparam logic [7:0]  A_IMASK = 8'h0C;
  localparam logic [7:0]  A_PRES  = 8'h10;
  localparam logic [7:0]  A_WORD0 = 8'h20;
  localparam logic [2:0]  A_WPAGE = 3'h1;
  localparam int          C_HOLD_IN  = 0;
  localparam int          C_HOLD_OUT = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam int          S_READY = 0;
  localparam int          S_DISC  = 1;
  localparam int          S_CFG   = 2;
  localparam int          I_LINK  = 0;
  localparam int          I_READY = 1;
  localparam int          I_CFG   = 2;
  localparam int          IRQ_W   = 3;
  localparam int          N_ADDR  = 28;
  localparam int          N_WORDS = 8;
  localparam logic [4:0]  LAST_SLOT = 5'h1D;
  localparam logic [4:0]  EXP2_BASE = 5'h18;
  localparam logic [27:0] SECOND_WORD = 28'h0CF0F0F0;
  localparam logic [1:0]  IN_GROUP = 2'h1;
  localparam logic [1:0]  PT4 = 2'h0;
  localparam logic [1:0]  PT8 = 2'h1;
  localparam int          CLK_NS  = 4;
  localparam int          SLOT_NS = 1200000;
  localparam int          SLOT_CYC = SLOT_NS / CLK_NS;
  localparam logic [2:0]  DISC_PASSES = 3'h3;
  typedef enum logic [1:0] {ST_PICK, ST_SLOT, ST_CHECK} rilm_state_t;
endpackage
`default_nettype wire

// ===== src/rilm_top.sv
/*
  Remote I/O link master: APB register file, slave discovery, polling
  of slave addresses in fixed-length slots, host I/O word mapping.
  Assumes an external transceiver that sends one poll per strobe and
  returns data, width and an acknowledge on pins asynchronous to pclk.
*/
// Contract
// - After reset every slave is discovered before ready is raised.
// - Ready is presented as bit 0 of the host status word.
// - A transmission error drops ready within 1 s.
// - On an error inputs and outputs follow the hold settings.
// - Units are polled one at a time and answer only when polled.
// - A scan is the present units plus two slots of 1.2 ms each.
// - Host I/O is sized to two words or one word by a switch.
// - 4-, 8- and 16-point slaves map to nibbles, bytes and words.
// - A second-word address in one-word mode is a config error.
`default_nettype none
module rilm_top
  import rilm_pkg::*;
#(
  parameter int SLOT_CYCLES = rilm_pkg::SLOT_CYC
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        link_ack,
  input  wire  logic        link_err,
  input  wire  logic [15:0] link_data,
  input  wire  logic [1:0]  link_width,
  input  wire  logic        size_one_word,
  output logic              poll_strobe,
  output logic [4:0]        poll_addr,
  output logic [15:0]       poll_data,
  output logic              link_ready,
  output logic              irq
);
  import rilm_pkg::*;

  logic [20:0]       sync1_reg;
  logic [20:0]       sync2_reg;
  logic              ack_d_reg;
  logic              ack_rise;
  logic              err_s;
  logic              one_s;
  logic [1:0]        width_s;
  logic [15:0]       data_s;

  rilm_state_t       st_reg;
  logic              disc_reg;
  logic [2:0]        pass_reg;
  logic [4:0]        idx_reg;
  logic [23:0]       cnt_reg;
  logic              got_reg;
  logic              lerr_reg;
  logic [27:0]       pres_reg;
  logic              ready_reg;
  logic              cfg_reg;
  logic              strobe_reg;
  logic [4:0]        paddr_reg;
  logic [15:0]       pdata_reg;

  logic [1:0]        ctrl_reg;
  logic [IRQ_W-1:0]  istat_reg;
  logic [IRQ_W-1:0]  imask_reg;
  logic [IRQ_W-1:0]  iset;
  logic              irq_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [15:0]       word_reg [N_WORDS];

  logic              slot_end;
  logic              run_fail;
  logic              cap_en;
  logic [2:0]        cur_w;
  logic [15:0]       cap_mask;
  logic [15:0]       cap_val;
  logic              wr_en;
  logic [31:0]       rd_val;
  logic              rd_hit;

  // Word of a slave address; one-word mode folds the pair onto its first
  function automatic logic [2:0] word_of(input logic [4:0] a, input logic one);
    logic [2:0] w;
    w = (a < EXP2_BASE) ? a[4:2] : {2'h3, a[1]};
    if (one) begin
      w[0] = 1'b0;
    end
    return w;
  endfunction

  // Pins are asynchronous; data must settle before ack rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      ack_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {size_one_word, link_width, link_err, link_data, link_ack};
      sync2_reg <= sync1_reg;
      ack_d_reg <= sync2_reg[0];
    end
  end

  assign data_s   = sync2_reg[16:1];
  assign err_s    = sync2_reg[17];
  assign width_s  = sync2_reg[19:18];
  assign one_s    = sync2_reg[20];
  assign ack_rise = sync2_reg[0] & ~ack_d_reg;

  assign slot_end = (st_reg == ST_SLOT) && (cnt_reg == 24'(SLOT_CYCLES - 1));
  // A present unit that stays silent or flags an error breaks the link
  assign run_fail = slot_end && !disc_reg && (idx_reg < 5'(N_ADDR)) &&
                    (!got_reg || lerr_reg);
  assign cur_w    = word_of(idx_reg, one_s);
  assign cap_en   = (st_reg == ST_SLOT) && !disc_reg && ack_rise &&
                    (idx_reg[4:3] == IN_GROUP);

  always_comb begin
    case (width_s)
      PT4:     cap_mask = 16'h000F << {idx_reg[1:0], 2'h0};
      PT8:     cap_mask = 16'h00FF << {idx_reg[1], 3'h0};
      default: cap_mask = 16'hFFFF;
    endcase
    cap_val = (data_s << (cap_mask == 16'hFFFF ? 4'h0 :
                          (width_s == PT4 ? {idx_reg[1:0], 2'h0} :
                                            {idx_reg[1], 3'h0}))) & cap_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= ST_PICK;
      disc_reg <= 1'b1;
      pass_reg <= 3'h0;
      idx_reg  <= 5'h0;
      cnt_reg  <= 24'h0;
      got_reg  <= 1'b0;
      lerr_reg <= 1'b0;
      pres_reg <= 28'h0;
    end else begin
      case (st_reg)
        ST_PICK: begin
          if (disc_reg && idx_reg >= 5'(N_ADDR)) begin
            idx_reg  <= 5'h0;
            pass_reg <= pass_reg + 3'h1;
            if (pass_reg + 3'h1 == DISC_PASSES) begin
              st_reg <= ST_CHECK;
            end
          end else if (!disc_reg && idx_reg < 5'(N_ADDR) && !pres_reg[idx_reg]) begin
            idx_reg <= idx_reg + 5'h1;
          end else begin
            st_reg   <= ST_SLOT;
            cnt_reg  <= 24'h0;
            got_reg  <= 1'b0;
            lerr_reg <= 1'b0;
          end
        end
        ST_SLOT: begin
          cnt_reg <= cnt_reg + 24'h1;
          if (ack_rise) begin
            got_reg <= 1'b1;
          end
          if (err_s) begin
            lerr_reg <= 1'b1;
          end
          if (slot_end) begin
            st_reg <= ST_PICK;
            if (run_fail) begin
              disc_reg <= 1'b1;
              pass_reg <= 3'h0;
              idx_reg  <= 5'h0;
              pres_reg <= 28'h0;
            end else begin
              if (disc_reg && (got_reg || ack_rise)) begin
                pres_reg[idx_reg] <= 1'b1;
              end
              idx_reg <= (idx_reg == LAST_SLOT) ? 5'h0 : idx_reg + 5'h1;
            end
          end
        end
        ST_CHECK: begin
          st_reg  <= ST_PICK;
          idx_reg <= 5'h0;
          if (one_s && |(pres_reg & SECOND_WORD)) begin
            pass_reg <= 3'h0;
            pres_reg <= 28'h0;
          end else begin
            disc_reg <= 1'b0;
          end
        end
        default: st_reg <= ST_PICK;
      endcase
    end
  end

  // Ready and config error flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      cfg_reg   <= 1'b0;
    end else begin
      if (run_fail) begin
        ready_reg <= 1'b0;
      end else if (st_reg == ST_CHECK) begin
        cfg_reg   <= one_s && |(pres_reg & SECOND_WORD);
        ready_reg <= !(one_s && |(pres_reg & SECOND_WORD));
      end
    end
  end

  // Poll request; outputs go dark on error unless held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_reg <= 1'b0;
      paddr_reg  <= 5'h0;
      pdata_reg  <= 16'h0;
    end else begin
      strobe_reg <= 1'b0;
      if (st_reg == ST_PICK && idx_reg < 5'(N_ADDR) &&
          (disc_reg || pres_reg[idx_reg])) begin
        strobe_reg <= 1'b1;
        paddr_reg  <= idx_reg;
        pdata_reg  <= (disc_reg && !ctrl_reg[C_HOLD_OUT]) ? 16'h0 : word_reg[cur_w];
      end
    end
  end

  assign wr_en = psel && penable && pready_reg && pwrite;

  generate
    for (genvar w = 0; w < N_WORDS; w++) begin : g_word
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          word_reg[w] <= 16'h0;
        end else if (3'(w) >> 1 == 3'(IN_GROUP)) begin
          if (run_fail && !ctrl_reg[C_HOLD_IN]) begin
            word_reg[w] <= 16'h0;
          end else if (cap_en && cur_w == 3'(w)) begin
            word_reg[w] <= (word_reg[w] & ~cap_mask) | cap_val;
          end
        end else if (wr_en && paddr == A_WORD0 + 8'(4 * w)) begin
          word_reg[w] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // Control, mask and sticky status; a new event beats a clear
  assign iset = {(st_reg == ST_CHECK) && one_s && |(pres_reg & SECOND_WORD),
                 (st_reg == ST_CHECK) && !(one_s && |(pres_reg & SECOND_WORD)),
                 run_fail};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= CTRL_RST;
      imask_reg <= '0;
      istat_reg <= '0;
      irq_reg   <= 1'b0;
    end else begin
      if (wr_en && paddr == A_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (wr_en && paddr == A_IMASK) begin
        imask_reg <= pwdata[IRQ_W-1:0];
      end
      istat_reg <= (istat_reg & ~((wr_en && paddr == A_ISTAT) ?
                                   pwdata[IRQ_W-1:0] : '0)) | iset;
      irq_reg   <= |(istat_reg & imask_reg);
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      A_CTRL:  rd_val = {30'h0, ctrl_reg};
      A_STAT:  rd_val = {29'h0, cfg_reg, disc_reg, ready_reg};
      A_ISTAT: rd_val = {29'h0, istat_reg};
      A_IMASK: rd_val = {29'h0, imask_reg};
      A_PRES:  rd_val = {4'h0, pres_reg};
      default: begin
        rd_hit = (paddr[7:5] == A_WPAGE) && (paddr[1:0] == 2'h0);
        rd_val = rd_hit ? {16'h0, word_reg[paddr[4:2]]} : 32'h0;
      end
    endcase
  end

  // Answer is prepared in setup so the access phase has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= psel && !penable;
      pslverr_reg <= psel && !penable && !rd_hit;
      prdata_reg  <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign poll_strobe = strobe_reg;
  assign poll_addr   = paddr_reg;
  assign poll_data   = pdata_reg;
  assign link_ready  = ready_reg;
  assign irq         = irq_reg;

  sequence s_fail;
    run_fail;
  endsequence

  sequence s_poll;
    strobe_reg ##1 !strobe_reg;
  endsequence

  chk_disc_no_ready: assert property (@(posedge pclk) disable iff (!presetn)
    disc_reg |-> !ready_reg)
    else $error("ready high during discovery");

  chk_err_drop: assert property (@(posedge pclk) disable iff (!presetn)
    s_fail |=> !ready_reg && disc_reg && istat_reg[I_LINK])
    else $error("ready not dropped after link error");

  chk_poll_present: assert property (@(posedge pclk) disable iff (!presetn)
    strobe_reg && !disc_reg |-> pres_reg[paddr_reg])
    else $error("polled an absent unit");

  chk_poll_single: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(strobe_reg) |-> s_poll)
    else $error("poll strobe longer than one cycle");

  chk_slot_bound: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == ST_SLOT |-> cnt_reg < 24'(SLOT_CYCLES))
    else $error("slot longer than its bound");

  chk_cfg_error: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == ST_CHECK && one_s && |(pres_reg & SECOND_WORD) |=> cfg_reg && !ready_reg)
    else $error("second-word address not reported");

  chk_hold_in: assert property (@(posedge pclk) disable iff (!presetn)
    s_fail and !ctrl_reg[C_HOLD_IN] |=> word_reg[2] == 16'h0 && word_reg[3] == 16'h0)
    else $error("input words not cleared on error");

  chk_nibble_map: assert property (@(posedge pclk) disable iff (!presetn)
    cap_en && width_s == PT4 |=> ((word_reg[$past(cur_w)] >> {$past(idx_reg[1:0]), 2'h0})
      & 16'h000F) == ($past(data_s) & 16'h000F))
    else $error("4-point data in wrong nibble");

  chk_ready_out: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == A_STAT |=> prdata[S_READY] == $past(ready_reg))
    else $error("status bit 0 differs from ready");
endmodule
`default_nettype wire
